//--- pkg/cfrc_pkg.sv
// Constants and types for the current fault response control block.
// Assumes one 10 MHz clock and two output pages.
package cfrc_pkg;

  // ----------------------------------------------------------------------
  // Command codes and register layout
  // ----------------------------------------------------------------------
  localparam logic [7:0] OC_RESP_CMD   = 8'hE5;  // Overcurrent response
  localparam logic [7:0] UC_RESP_CMD   = 8'hE6;  // Undercurrent response
  localparam logic [7:0] RESP_RESET    = 8'h80;  // Shut down, no retries
  localparam int         MODE_MSB      = 7;
  localparam int         MODE_LSB      = 6;
  localparam int         RETRY_MSB     = 5;
  localparam int         RETRY_LSB     = 3;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h2;   // Disable without delay
  localparam logic [2:0] RETRY_NONE    = 3'h0;   // Stay off until cleared
  localparam logic [2:0] RETRY_FOREVER = 3'h7;   // Restart continuously
  localparam int         PAGES         = 2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ  = 10000;
  localparam int RETRY_TIME_MS = 70;
  localparam int RETRY_CYCLES  = RETRY_TIME_MS * CLK_FREQ_KHZ;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] oc_cfg;  // overcurrent_fault_response_cfg
    logic [7:0] uc_cfg;  // undercurrent_fault_response_cfg
  } cfrc_resp_type;

  typedef struct packed {
    logic uc;  // Undercurrent flag
    logic oc;  // Overcurrent flag
  } cfrc_flags_type;

  typedef enum logic [1:0] {
    CH_RUN  = 2'b00,  // Output permitted
    CH_WAIT = 2'b01,  // Off, retry interval running
    CH_HOLD = 2'b10   // Off until faults are cleared
  } cfrc_ch_state_type;

endpackage : cfrc_pkg

//--- hdl/cfrc_retry_ch.sv
// Per-output shutdown and retry sequencer.
// Assumes fault and stop requests are synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module cfrc_retry_ch #(
  parameter int RETRY_CYCLES = cfrc_pkg::RETRY_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic shut_i,     // Fault calling for shutdown
  input  wire logic retry_i,    // Continuous retry selected
  input  wire logic stop_i,     // Commanded off, bias lost, other fault
  input  wire logic clear_i,    // Clear-faults command
  output logic      out_en_o,   // Output allowed to run
  output logic      restart_o   // One-cycle restart request
);

  localparam int CNT_W = $clog2(RETRY_CYCLES);

  typedef struct packed {
    cfrc_pkg::cfrc_ch_state_type st;
    logic [CNT_W-1:0]            count;
    logic                        out_en;
    logic                        restart;
  } cfrc_ch_type;

  cfrc_ch_type ch_reg;
  cfrc_ch_type ch_next;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    ch_next         = ch_reg;
    ch_next.restart = 1'b0;
    unique case (ch_reg.st)
      cfrc_pkg::CH_RUN: begin
        if (shut_i) begin
          ch_next.out_en = 1'b0;
          ch_next.count  = '0;
          if (retry_i && !stop_i) begin
            ch_next.st = cfrc_pkg::CH_WAIT;
          end else begin
            ch_next.st = cfrc_pkg::CH_HOLD;
          end
        end
      end
      cfrc_pkg::CH_WAIT: begin
        if (stop_i) begin
          ch_next.st = cfrc_pkg::CH_HOLD;
        end else if (ch_reg.count == CNT_W'(RETRY_CYCLES - 1)) begin
          // Restart without looking at the fault
          ch_next.st      = cfrc_pkg::CH_RUN;
          ch_next.out_en  = 1'b1;
          ch_next.restart = 1'b1;
        end else begin
          ch_next.count = ch_reg.count + CNT_W'(1);
        end
      end
      cfrc_pkg::CH_HOLD: begin
        if (clear_i) begin
          ch_next.st     = cfrc_pkg::CH_RUN;
          ch_next.out_en = 1'b1;
        end
      end
      default: begin
        ch_next.st     = cfrc_pkg::CH_HOLD;
        ch_next.out_en = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ch_reg <= '{st: cfrc_pkg::CH_RUN, count: '0, out_en: 1'b1,
                 restart: 1'b0};
    end else begin
      ch_reg <= ch_next;
    end
  end

  assign out_en_o  = ch_reg.out_en;
  assign restart_o = ch_reg.restart;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_wait_done;
    ch_reg.st == cfrc_pkg::CH_WAIT &&
    ch_reg.count == CNT_W'(RETRY_CYCLES - 1) && !stop_i;
  endsequence

  property p_retry_interval;
    @(posedge clk_i) disable iff (reset_i)
    $rose(ch_reg.restart) |-> $past(ch_reg.st) == cfrc_pkg::CH_WAIT &&
      $past(ch_reg.count) == CNT_W'(RETRY_CYCLES - 1);
  endproperty
  a_retry_interval: assert property (p_retry_interval)
    else $error("restart not at end of retry interval");

  property p_restart_blind;
    @(posedge clk_i) disable iff (reset_i)
    s_wait_done |=> ch_reg.out_en && ch_reg.restart &&
      ch_reg.st == cfrc_pkg::CH_RUN;
  endproperty
  a_restart_blind: assert property (p_restart_blind)
    else $error("retry did not restart output");

  property p_stop_retry;
    @(posedge clk_i) disable iff (reset_i)
    (ch_reg.st == cfrc_pkg::CH_WAIT && stop_i) |=>
      ch_reg.st == cfrc_pkg::CH_HOLD [*2] or
      (ch_reg.st == cfrc_pkg::CH_HOLD ##1 ch_reg.st == cfrc_pkg::CH_RUN);
  endproperty
  a_stop_retry: assert property (p_stop_retry)
    else $error("retry not stopped");

  property p_hold_off;
    @(posedge clk_i) disable iff (reset_i)
    (ch_reg.st == cfrc_pkg::CH_HOLD && !clear_i) |=> !ch_reg.out_en;
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("held output came back on");

  property p_wait_start;
    @(posedge clk_i) disable iff (reset_i)
    (ch_reg.st == cfrc_pkg::CH_RUN && shut_i && retry_i && !stop_i) |=>
      ch_reg.st == cfrc_pkg::CH_WAIT && ch_reg.count == '0 ##1
      (ch_reg.count == CNT_W'(1) || ch_reg.st == cfrc_pkg::CH_HOLD);
  endproperty
  a_wait_start: assert property (p_wait_start)
    else $error("retry timer did not start");

endmodule : cfrc_retry_ch
`default_nettype wire

//--- hdl/cfrc_top.sv
// Current fault response control for two output pages.
// Assumes fault, command and status inputs come from logic on clk_i and
// that command decoding hands over one byte per command code.
//
// Functional notes
// - An overcurrent fault sets the overcurrent status bit of its page.
// - An undercurrent fault sets the undercurrent status bit of its page.
// - Retrying waits one 70 ms interval between restart attempts.
// - Both response bytes reset to 80h, shutdown with no retries.
// - Any current fault pulls the alert pin low and sets its flag.
// - Fault flags clear only on the clear-faults command.
// - Mode 10 in bits 7:6 turns the output off at once; it retries only with retry code 111.
// - Retry code 000 keeps the output off until faults are cleared.
// - Retry code 111 restarts forever without checking the fault.
// - Retrying stops on command off, bias loss or another fault.
// - Each page holds its own pair of response bytes.
// - The response bytes are host readable, writable, and protectable.
`timescale 1ns/10ps
`default_nettype none
module cfrc_top #(
  parameter int RETRY_CYCLES = cfrc_pkg::RETRY_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Command port
  input  wire logic       cmd_wr_i,        // Write strobe, one cycle
  input  wire logic       cmd_rd_i,        // Read strobe, one cycle
  input  wire logic       page_i,          // Selected output page
  input  wire logic [7:0] cmd_code_i,      // Command code
  input  wire logic [7:0] cmd_wdata_i,     // Write byte
  input  wire logic       write_protect_i, // Blocks configuration writes
  input  wire logic       clear_faults_i,  // Clear-faults command
  output logic      [7:0] cmd_rdata_o,     // Read byte
  output logic            cmd_rvalid_o,    // Read answer, one cycle
  // Fault and power inputs
  input  wire logic [1:0] oc_fault_i,      // Overcurrent per page
  input  wire logic [1:0] uc_fault_i,      // Undercurrent per page
  input  wire logic [1:0] commanded_on_i,  // Pin and operation state
  input  wire logic       bias_ok_i,       // Bias supply present
  input  wire logic [1:0] other_fault_i,   // Other shutdown faults
  // Outputs
  output logic      [1:0] output_enable_o, // Output permitted per page
  output logic      [1:0] restart_req_o,   // Restart request pulse
  output cfrc_pkg::cfrc_flags_type [1:0] fault_flags_o,
  output logic            alert_output_pin_o,    // Pin level, always 0
  output logic            alert_output_pin_oe_o  // High: pull pin low
);

  typedef struct packed {
    cfrc_pkg::cfrc_resp_type  [1:0] cfg;
    cfrc_pkg::cfrc_flags_type [1:0] flags;
    logic                     [7:0] rdata;
    logic                           rvalid;
    logic                           alert;
  } cfrc_state_type;

  cfrc_state_type state_reg;
  cfrc_state_type state_next;

  logic [1:0] shut;
  logic [1:0] retry;
  logic [1:0] stop;
  logic       wr_ok;

  // ----------------------------------------------------------------------
  // Fault response decode per page
  // ----------------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < cfrc_pkg::PAGES; p++) begin
      shut[p] = (oc_fault_i[p] &&
                 state_reg.cfg[p].oc_cfg[cfrc_pkg::MODE_MSB:
                                         cfrc_pkg::MODE_LSB]
                 == cfrc_pkg::MODE_SHUTDOWN) ||
                (uc_fault_i[p] &&
                 state_reg.cfg[p].uc_cfg[cfrc_pkg::MODE_MSB:
                                         cfrc_pkg::MODE_LSB]
                 == cfrc_pkg::MODE_SHUTDOWN);
      // Overcurrent setting wins when both faults arrive together
      if (oc_fault_i[p]) begin
        retry[p] = state_reg.cfg[p].oc_cfg[cfrc_pkg::RETRY_MSB:
                                           cfrc_pkg::RETRY_LSB]
                   == cfrc_pkg::RETRY_FOREVER;
      end else begin
        retry[p] = state_reg.cfg[p].uc_cfg[cfrc_pkg::RETRY_MSB:
                                           cfrc_pkg::RETRY_LSB]
                   == cfrc_pkg::RETRY_FOREVER;
      end
      stop[p] = !commanded_on_i[p] || !bias_ok_i ||
                other_fault_i[p];
    end
  end

  assign wr_ok = cmd_wr_i && !write_protect_i;

  // ----------------------------------------------------------------------
  // Registers, flags, alert and read path
  // ----------------------------------------------------------------------
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;
    // Configuration writes go to the selected page only
    if (wr_ok && cmd_code_i == cfrc_pkg::OC_RESP_CMD) begin
      state_next.cfg[page_i].oc_cfg = cmd_wdata_i;
    end
    if (wr_ok && cmd_code_i == cfrc_pkg::UC_RESP_CMD) begin
      state_next.cfg[page_i].uc_cfg = cmd_wdata_i;
    end
    // Flags: clear first so a fault in the same cycle wins
    if (clear_faults_i) begin
      state_next.flags = '0;
    end
    for (int p = 0; p < cfrc_pkg::PAGES; p++) begin
      if (oc_fault_i[p]) begin
        state_next.flags[p].oc = 1'b1;
      end
      if (uc_fault_i[p]) begin
        state_next.flags[p].uc = 1'b1;
      end
    end
    state_next.alert = |state_next.flags;
    // Read answer; unknown codes read as zero
    if (cmd_rd_i) begin
      state_next.rvalid = 1'b1;
      unique case (cmd_code_i)
        cfrc_pkg::OC_RESP_CMD: begin
          state_next.rdata = state_reg.cfg[page_i].oc_cfg;
        end
        cfrc_pkg::UC_RESP_CMD: begin
          state_next.rdata = state_reg.cfg[page_i].uc_cfg;
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= '{cfg: {2{cfrc_pkg::RESP_RESET, cfrc_pkg::RESP_RESET}},
                    flags: '0, rdata: 8'h00, rvalid: 1'b0,
                    alert: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Retry sequencers, one per page
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < cfrc_pkg::PAGES; g++) begin : g_page
    cfrc_retry_ch #(
      .RETRY_CYCLES (RETRY_CYCLES)
    ) u_ch (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .shut_i    (shut[g]),
      .retry_i   (retry[g]),
      .stop_i    (stop[g]),
      .clear_i   (clear_faults_i),
      .out_en_o  (output_enable_o[g]),
      .restart_o (restart_req_o[g])
    );
  end

  assign cmd_rdata_o           = state_reg.rdata;
  assign cmd_rvalid_o          = state_reg.rvalid;
  assign fault_flags_o         = state_reg.flags;
  assign alert_output_pin_o    = 1'b0;
  assign alert_output_pin_oe_o = state_reg.alert;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_oc_flag;
    @(posedge clk_i) disable iff (reset_i)
    oc_fault_i[0] |=> state_reg.flags[0].oc;
  endproperty
  a_oc_flag: assert property (p_oc_flag)
    else $error("overcurrent flag not set");

  property p_uc_flag;
    @(posedge clk_i) disable iff (reset_i)
    uc_fault_i[1] |=> state_reg.flags[1].uc;
  endproperty
  a_uc_flag: assert property (p_uc_flag)
    else $error("undercurrent flag not set");

  property p_reset_cfg;
    @(posedge clk_i)
    reset_i |=> state_reg.cfg[0].oc_cfg == 8'h80 &&
      state_reg.cfg[1].uc_cfg == 8'h80;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg)
    else $error("response byte reset value wrong");

  property p_alert;
    @(posedge clk_i) disable iff (reset_i)
    (|oc_fault_i || |uc_fault_i) |=> alert_output_pin_oe_o &&
      !alert_output_pin_o;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert not driven on fault");

  property p_sticky;
    @(posedge clk_i) disable iff (reset_i)
    (state_reg.flags[0].oc && !clear_faults_i) |=>
      state_reg.flags[0].oc && alert_output_pin_oe_o;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without clear");

  // A restart due in the same cycle still wins over a fresh fault
  property p_shutdown;
    @(posedge clk_i) disable iff (reset_i)
    (oc_fault_i[0] && state_reg.cfg[0].oc_cfg[7:6] == 2'h2) |=>
      !output_enable_o[0] || restart_req_o[0];
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("output not disabled at once");

  property p_page_indep;
    @(posedge clk_i) disable iff (reset_i)
    (cmd_wr_i && page_i == 1'b0) |=> $stable(state_reg.cfg[1]);
  endproperty
  a_page_indep: assert property (p_page_indep)
    else $error("write reached the other page");

  property p_protect;
    @(posedge clk_i) disable iff (reset_i)
    (cmd_wr_i && write_protect_i) |=> $stable(state_reg.cfg);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected write changed a response byte");

  // Flags and shutdown on the other page and fault kind
  property p_oc_flag_p1;
    @(posedge clk_i) disable iff (reset_i)
    oc_fault_i[1] |=> state_reg.flags[1].oc;
  endproperty
  a_oc_flag_p1: assert property (p_oc_flag_p1)
    else $error("overcurrent flag of page 1 not set");

  property p_uc_flag_p0;
    @(posedge clk_i) disable iff (reset_i)
    uc_fault_i[0] |=> state_reg.flags[0].uc;
  endproperty
  a_uc_flag_p0: assert property (p_uc_flag_p0)
    else $error("undercurrent flag of page 0 not set");

  property p_shutdown_uc;
    @(posedge clk_i) disable iff (reset_i)
    (uc_fault_i[1] && state_reg.cfg[1].uc_cfg[7:6] == 2'h2) |=>
      !output_enable_o[1] || restart_req_o[1];
  endproperty
  a_shutdown_uc: assert property (p_shutdown_uc)
    else $error("page 1 output not disabled at once");

  // Unused mode codes only flag the fault; a running output stays on
  property p_no_shut;
    @(posedge clk_i) disable iff (reset_i)
    (uc_fault_i[0] && !oc_fault_i[0] && output_enable_o[0] &&
     state_reg.cfg[0].uc_cfg[7:6] != 2'h2) |=> output_enable_o[0];
  endproperty
  a_no_shut: assert property (p_no_shut)
    else $error("unused mode code shut the output");

  // Clear with no fault pending drops every flag and the alert
  property p_clear;
    @(posedge clk_i) disable iff (reset_i)
    (clear_faults_i && !(|oc_fault_i) && !(|uc_fault_i)) |=>
      state_reg.flags == '0 && !alert_output_pin_oe_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear-faults left a flag set");

  property p_sticky_uc;
    @(posedge clk_i) disable iff (reset_i)
    (state_reg.flags[1].uc && !clear_faults_i) |=> state_reg.flags[1].uc;
  endproperty
  a_sticky_uc: assert property (p_sticky_uc)
    else $error("undercurrent flag dropped without clear");

  // Read answer one cycle after the strobe, with the stored byte
  sequence s_read_oc;
    cmd_rd_i && cmd_code_i == cfrc_pkg::OC_RESP_CMD;
  endsequence

  property p_read_answer;
    @(posedge clk_i) disable iff (reset_i)
    cmd_rd_i |=> cmd_rvalid_o;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered");

  property p_read_oc;
    @(posedge clk_i) disable iff (reset_i)
    s_read_oc |=> cmd_rdata_o == $past(state_reg.cfg[page_i].oc_cfg);
  endproperty
  a_read_oc: assert property (p_read_oc)
    else $error("overcurrent response byte read wrong");

  property p_write_lands;
    @(posedge clk_i) disable iff (reset_i)
    (cmd_wr_i && !write_protect_i && page_i == 1'b1 &&
     cmd_code_i == cfrc_pkg::OC_RESP_CMD) |=>
      state_reg.cfg[1].oc_cfg == $past(cmd_wdata_i);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("response byte write lost");

  property p_page_indep_p1;
    @(posedge clk_i) disable iff (reset_i)
    (cmd_wr_i && page_i == 1'b1) |=> $stable(state_reg.cfg[0]);
  endproperty
  a_page_indep_p1: assert property (p_page_indep_p1)
    else $error("page 1 write reached page 0");

endmodule : cfrc_top
`default_nettype wire

//--- test/cfrc_host_model.sv
// Host side model: issues one-byte command writes and reads.
// Assumes the device answers a read one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module cfrc_host_model (
  input  wire logic       clk_i,
  input  wire logic       rvalid_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic            page_o,
  output logic      [7:0] code_o,
  output logic      [7:0] wdata_o
);
  // Idle lines at time zero
  initial begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    page_o  = 1'b0;
    code_o  = 8'h00;
    wdata_o = 8'h00;
  end

  // One write strobe; released lines show the inverse value
  task automatic write(input logic pg, input logic [7:0] cd,
                       input logic [7:0] dt);
    @(posedge clk_i);
    wr_o    <= 1'b1;
    page_o  <= pg;
    code_o  <= cd;
    wdata_o <= dt;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    page_o  <= ~pg;
    code_o  <= ~cd;
    wdata_o <= ~dt;
  endtask : write

  // One read strobe, then a bounded wait for the answer
  task automatic read(input logic pg, input logic [7:0] cd,
                      output logic [7:0] dt, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    dt = 8'h00;
    @(posedge clk_i);
    rd_o   <= 1'b1;
    page_o <= pg;
    code_o <= cd;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    page_o <= ~pg;
    code_o <= ~cd;
    while (!ok && n < 4) begin
      @(posedge clk_i);
      ok = (rvalid_i === 1'b1);
      dt = rdata_i;
      n++;
    end
  endtask : read
endmodule : cfrc_host_model
`default_nettype wire

//--- test/cfrc_top_bench.sv
// Bench: a cycle model of the block compared with every output.
// Assumes the host model and a retry interval cut to 8 cycles.
`timescale 1ns/10ps
`default_nettype none
module cfrc_top_bench;
  localparam int N = 8;  // Shortened retry interval
  logic       clk_i, reset_i, cmd_wr_i, cmd_rd_i, page_i;
  logic [7:0] cmd_code_i, cmd_wdata_i, cmd_rdata_o, m_rd;
  logic       write_protect_i, clear_faults_i, bias_ok_i, cmd_rvalid_o;
  logic [1:0] oc_fault_i, uc_fault_i, commanded_on_i, other_fault_i;
  logic [1:0] output_enable_o, restart_req_o, m_oc, m_uc, m_en, m_rs;
  logic       alert_output_pin_o, alert_output_pin_oe_o, m_rv, m_al;
  logic [3:0] m_fl;
  logic [7:0] m_cfg [2][2];
  int         m_st [2];
  int         m_cnt [2];
  int         bad_count, tests_run, seed;
  cfrc_pkg::cfrc_flags_type [1:0] fault_flags_o;

  cfrc_top #(.RETRY_CYCLES(N)) i_dut (.clk_i, .reset_i, .cmd_wr_i,
    .cmd_rd_i, .page_i, .cmd_code_i, .cmd_wdata_i, .write_protect_i,
    .clear_faults_i, .cmd_rdata_o, .cmd_rvalid_o, .oc_fault_i,
    .uc_fault_i, .commanded_on_i, .bias_ok_i, .other_fault_i,
    .output_enable_o, .restart_req_o, .fault_flags_o,
    .alert_output_pin_o, .alert_output_pin_oe_o);
  cfrc_host_model i_host (.clk_i, .rvalid_i(cmd_rvalid_o),
    .rdata_i(cmd_rdata_o), .wr_o(cmd_wr_i), .rd_o(cmd_rd_i),
    .page_o(page_i), .code_o(cmd_code_i), .wdata_o(cmd_wdata_i));

  // Clock at 10 MHz
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------------
  // Cycle model fed with the inputs sampled at each edge
  // --------------------------------------------------------------------
  always @(posedge clk_i) begin
    logic sh, rt, sp;
    if (reset_i) begin
      m_cfg = '{'{8'h80, 8'h80}, '{8'h80, 8'h80}};
      {m_oc, m_uc, m_rs, m_rv, m_rd} = '0;
      m_en = 2'b11;
      m_st = '{0, 0};
    end else begin
      m_rv = cmd_rd_i;
      m_rs = 2'b00;
      if (cmd_rd_i)
        m_rd = (cmd_code_i == cfrc_pkg::OC_RESP_CMD) ? m_cfg[page_i][0] :
               (cmd_code_i == cfrc_pkg::UC_RESP_CMD) ? m_cfg[page_i][1] :
               8'h00;
      for (int p = 0; p < 2; p++) begin
        sh = (oc_fault_i[p] && m_cfg[p][0][7:6] == 2'b10) ||
             (uc_fault_i[p] && m_cfg[p][1][7:6] == 2'b10);
        rt = (oc_fault_i[p] ? m_cfg[p][0][5:3] : m_cfg[p][1][5:3]) == 3'h7;
        sp = !commanded_on_i[p] || !bias_ok_i || other_fault_i[p];
        m_oc[p] = oc_fault_i[p] | (m_oc[p] & !clear_faults_i);
        m_uc[p] = uc_fault_i[p] | (m_uc[p] & !clear_faults_i);
        case (m_st[p])
          0: if (sh) begin
            m_en[p] = 1'b0;
            m_st[p] = (rt && !sp) ? 1 : 2;
            m_cnt[p] = 0;
          end
          1: if (sp) m_st[p] = 2;
            else if (m_cnt[p] == N - 1) begin
              m_st[p] = 0;
              m_en[p] = 1'b1;
              m_rs[p] = 1'b1;
            end else m_cnt[p]++;
          default: if (clear_faults_i) begin
            m_st[p] = 0;
            m_en[p] = 1'b1;
          end
        endcase
      end
      if (cmd_wr_i && !write_protect_i &&
          (cmd_code_i == cfrc_pkg::OC_RESP_CMD ||
           cmd_code_i == cfrc_pkg::UC_RESP_CMD))
        m_cfg[page_i][cmd_code_i == cfrc_pkg::UC_RESP_CMD] = cmd_wdata_i;
    end
    m_fl = {m_uc[1], m_oc[1], m_uc[0], m_oc[0]};
    m_al = |m_fl;
  end

  // Compare every output once the edge has settled
  always @(negedge clk_i) begin
    if (!reset_i) begin
      chk(output_enable_o, m_en, "enable");
      chk(restart_req_o, m_rs, "restart");
      chk(fault_flags_o, m_fl, "flags");
      chk(alert_output_pin_oe_o, m_al, "alert");
      chk(alert_output_pin_o, 1'b0, "pin level");
      chk(cmd_rvalid_o, m_rv, "read valid");
      chk(cmd_rdata_o, m_rd, "read data");
    end
  end

  // --------------------------------------------------------------------
  // Helpers and verdict
  // --------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic rdq(input int pg, input int cd);
    logic [7:0] d;
    logic       ok;
    i_host.read(1'(pg), 8'(cd), d, ok);
    if (!ok) begin
      bad_count++;
      $display("wrong value at %0t: no read answer", $time);
      conclude();
    end
  endtask : rdq

  // Fault pulse of n cycles on one page
  task automatic hit(input int pg, input logic is_oc, input int n);
    @(posedge clk_i);
    if (is_oc) oc_fault_i[pg] <= 1'b1;
    else uc_fault_i[pg] <= 1'b1;
    cyc(n);
    oc_fault_i <= 2'b00;
    uc_fault_i <= 2'b00;
  endtask : hit

  task automatic clear;
    @(posedge clk_i);
    clear_faults_i <= 1'b1;
    @(posedge clk_i);
    clear_faults_i <= 1'b0;
  endtask : clear

  // Watchdog against a hang
  initial begin
    cyc(100000);
    bad_count++;
    conclude();
  end

  // Main sequence
  initial begin
    seed = 32'hc650;
    bad_count = 0;
    tests_run = 0;
    reset_i = 1'b1;
    write_protect_i = 1'b0;
    clear_faults_i = 1'b0;
    oc_fault_i = 2'b00;
    uc_fault_i = 2'b00;
    commanded_on_i = 2'b11;
    bias_ok_i = 1'b1;
    other_fault_i = 2'b00;
    cyc(3);
    reset_i <= 1'b0;
    // Reset bytes, random writes, protected and unmapped codes
    for (int p = 0; p < 2; p++) begin
      for (int c = 8'hE4; c < 8'hE8; c++) begin
        rdq(p, c);
        i_host.write(1'(p), 8'(c), 8'($random(seed)));
        rdq(p, c);
        @(posedge clk_i);
        write_protect_i <= 1'b1;
        i_host.write(1'(p), 8'(c), 8'($random(seed)));
        write_protect_i <= 1'b0;
        rdq(p, c);
      end
    end
    // Reset in mid-run brings the shutdown bytes back
    @(posedge clk_i);
    reset_i <= 1'b1;
    cyc(2);
    reset_i <= 1'b0;
    hit(0, 1'b1, 2);
    hit(1, 1'b0, 1);
    cyc(N + 4);
    clear();
    cyc(3);
    // Endless retry while the fault persists on page 1 only
    i_host.write(1'b1, cfrc_pkg::OC_RESP_CMD, 8'hB8);
    hit(1, 1'b1, 2 * N + 6);
    cyc(N + 4);
    clear();
    // Each stop source ends the retry wait
    for (int s = 0; s < 3; s++) begin
      hit(1, 1'b1, 1);
      cyc(2);
      if (s == 0) commanded_on_i <= 2'b01;
      if (s == 1) bias_ok_i <= 1'b0;
      if (s == 2) other_fault_i <= 2'b10;
      cyc(2);
      commanded_on_i <= 2'b11;
      bias_ok_i <= 1'b1;
      other_fault_i <= 2'b00;
      cyc(N + 2);
      clear();
    end
    // Every mode and retry code on the undercurrent byte of page 0
    for (int m = 0; m < 4; m++) begin
      for (int r = 0; r < 8; r++) begin
        i_host.write(1'b0, cfrc_pkg::UC_RESP_CMD,
                     {2'(m), 3'(r), 3'($random(seed))});
        hit(0, 1'b0, 1);
        cyc(N + 3);
        clear();
        cyc(1);
      end
    end
    conclude();
  end
endmodule : cfrc_top_bench
`default_nettype wire
